// ---- rx_page_pkg.sv ----
package rx_page_pkg;
   // Register offsets.
   localparam logic [7:0] OFS_RSVD_LO   = 8'h44;
   localparam logic [7:0] OFS_RSVD_HI   = 8'h49;
   localparam logic [7:0] OFS_LINK_CAP  = 8'h4A;
   localparam logic [7:0] OFS_RAW_EMBED = 8'h4B;
   localparam logic [7:0] OFS_PORT_SEL  = 8'h4C;
   localparam logic [7:0] OFS_PAGE_A_LO = 8'h4D;
   localparam logic [7:0] OFS_PAGE_A_HI = 8'h7F;
   localparam logic [7:0] OFS_PAGE_B_LO = 8'hD0;
   localparam logic [7:0] OFS_PAGE_B_HI = 8'hDF;
   // Field positions.
   localparam int CAP_CRC_BIT  = 4;
   localparam int EMB_CNT_HI   = 7;
   localparam int EMB_CNT_LO   = 6;
   localparam int EMB_CODE_HI  = 5;
   localparam int SEL_PHYS_BIT = 6;
   localparam int SEL_READ_BIT = 4;
   localparam int SEL_WR_HI    = 1;
   // Reset values.
   localparam logic       LINK_CAP_RESET  = 1'b0;
   localparam logic [7:0] RAW_EMBED_RESET = 8'h12;
   // Access sources: local port, control channel over port 0, over port 1.
   localparam int         NUM_SOURCES = 3;
   localparam logic [1:0] SRC_LOCAL   = 2'h0;
   localparam logic [1:0] SRC_LINK0   = 2'h1;
   localparam logic [1:0] SRC_LINK1   = 2'h2;
   // Per-source page-select defaults, indexed by source.
   localparam logic [2:0] SEL_READ_RESET = 3'h4;
   localparam logic [5:0] SEL_WR_RESET   = 6'h24;

   typedef struct packed {
      logic       write;
      logic       read;
      logic [1:0] source;
      logic [7:0] addr;
      logic [7:0] wdata;
   } reg_req_t;

   typedef struct packed {
      logic       frameStart;
      logic       longPkt;
      logic       rawTwelve;
      logic [5:0] csiType;
   } pkt_t;
endpackage

// ---- rx_port_register_paging.sv ----
`timescale 1ns/1ps
// What this block does
// RULE_01: Per-port capability bit lets encoder CRC errors raise the error flag; zero suppresses them.
// RULE_02: Software sets the capability bit and clears the separate encoder CRC disable bit.
// RULE_03: Embedded count zero in raw mode: every long packet uses the raw ten or twelve type.
// RULE_04: Count one to three: that many first long packets per frame carry the embedded code.
// RULE_05: Embedded count and code have no effect while the port accepts CSI-formatted input.
// RULE_06: Embedded lines use the six-bit embedded code, which resets to 0x12.
// RULE_07: Offsets 0x4A, 0x4B, 0x4D-0x7F and 0xD0-0xDF are paged per receive port.
// RULE_08: Reads of paged registers return the bank named by the read port selector.
// RULE_09: Paged writes update every bank whose write-enable bit is one, others stay unchanged.
// RULE_10: Each access source keeps its own port-select state, never disturbing another's.
// RULE_11: The physical port field reads zero through the local port.
// RULE_12: Through the control channel the physical port field reads the carrying port number.
// RULE_13: Read selector defaults to zero locally, to the carrying port for control-channel sources.
// RULE_14: Control-channel sources default to write-enabling their own port; local defaults to none.
// RULE_15: Reserved bits and offsets 0x44-0x49 read zero and ignore writes.
module rx_port_register_paging
   import rx_page_pkg::*;
#(
   parameter int NUM_PORTS = 2
) (
   // Clock and reset.
   input  wire logic       clk_sys,
   input  wire logic       rst,
   // Register access from the local port and the control channels.
   input  wire reg_req_t   req,
   output logic [7:0]      rdata,
   output logic            rdValid,
   // Steering for paged registers held outside this block.
   output logic [1:0]      pageWrite,
   output logic            pageReadPort,
   input  wire logic [7:0] pagedRdata [2],
   // Encoder CRC error reporting.
   input  wire logic [1:0] crcErrIn,
   output logic [1:0]      crcErrFlag,
   // Packet data type substitution.
   input  wire logic [1:0] rawMode,
   input  wire pkt_t       pktIn [2],
   input  wire logic [5:0] rawTenCode,
   input  wire logic [5:0] rawTwelveCode,
   output logic [5:0]      dtOut [2],
   output logic [1:0]      dtValid
);

   if (NUM_PORTS != 2) begin : g_check
      $error("Only two receive ports are supported.");
   end

   function automatic logic inPagedRange(input logic [7:0] a);
      inPagedRange = (a >= OFS_PAGE_A_LO && a <= OFS_PAGE_A_HI) ||
                     (a >= OFS_PAGE_B_LO && a <= OFS_PAGE_B_HI);
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Source decode.

   logic       srcValid;
   logic [1:0] srcIdx;
   logic       wrSel;
   logic       wrCap;
   logic       wrEmbed;
   logic       physPort;

   assign srcValid = (req.source == SRC_LOCAL) || (req.source == SRC_LINK0) || (req.source == SRC_LINK1);
   assign srcIdx   = srcValid ? req.source : SRC_LOCAL;
   assign wrSel    = req.write && srcValid && (req.addr == OFS_PORT_SEL);
   assign wrCap    = req.write && srcValid && (req.addr == OFS_LINK_CAP);
   assign wrEmbed  = req.write && srcValid && (req.addr == OFS_RAW_EMBED);
   assign physPort = (req.source == SRC_LINK1); // RULE_11 RULE_12

   ////////////////////////////////////////////////////////////////////////////////
   // Per-source page select.

   logic       readSel [NUM_SOURCES];
   logic [1:0] wrEn    [NUM_SOURCES];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int s = 0; s < NUM_SOURCES; s++) begin
            readSel[s] <= SEL_READ_RESET[s];        // RULE_13
            wrEn[s]    <= SEL_WR_RESET[2*s +: 2];   // RULE_14
         end
      end else if (wrSel) begin
         readSel[srcIdx] <= req.wdata[SEL_READ_BIT];            // RULE_10
         wrEn[srcIdx]    <= req.wdata[SEL_WR_HI:0];             // RULE_10
      end
   end

   // Paged writes are steered by the writing source's enables.
   assign pageWrite    = (req.write && srcValid && inPagedRange(req.addr)) ? wrEn[srcIdx] : 2'h0; // RULE_07 RULE_09
   assign pageReadPort = readSel[srcIdx]; // RULE_08

   ////////////////////////////////////////////////////////////////////////////////
   // Per-port banks.

   logic       crcEn     [2];
   logic [7:0] embedReg  [2];

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < 2; p++) begin
            crcEn[p]    <= LINK_CAP_RESET;
            embedReg[p] <= RAW_EMBED_RESET; // RULE_06
         end
      end else begin
         for (int p = 0; p < 2; p++) begin
            if (wrCap && wrEn[srcIdx][p]) begin              // RULE_07 RULE_09
               crcEn[p] <= req.wdata[CAP_CRC_BIT];           // RULE_15
            end
            if (wrEmbed && wrEn[srcIdx][p]) begin            // RULE_07 RULE_09
               embedReg[p] <= req.wdata;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read path: data follows the request by one cycle.

   logic [7:0] next_rdata;

   always_comb begin
      next_rdata = 8'h00; // RULE_15
      if (srcValid) begin
         if (req.addr == OFS_LINK_CAP) begin
            next_rdata[CAP_CRC_BIT] = crcEn[readSel[srcIdx]]; // RULE_08
         end else if (req.addr == OFS_RAW_EMBED) begin
            next_rdata = embedReg[readSel[srcIdx]];           // RULE_08
         end else if (req.addr == OFS_PORT_SEL) begin
            next_rdata[SEL_PHYS_BIT] = physPort;              // RULE_11 RULE_12
            next_rdata[SEL_READ_BIT] = readSel[srcIdx];
            next_rdata[SEL_WR_HI:0]  = wrEn[srcIdx];
         end else if (inPagedRange(req.addr)) begin
            next_rdata = pagedRdata[readSel[srcIdx]];         // RULE_08
         end
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         rdata   <= 8'h00;
         rdValid <= 1'b0;
      end else begin
         rdValid <= req.read;
         if (req.read) begin
            rdata <= next_rdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Encoder CRC error flag.

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         crcErrFlag <= 2'h0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            crcErrFlag[p] <= crcErrIn[p] && crcEn[p]; // RULE_01
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Embedded data type substitution for the first lines of a frame.

   logic [1:0] lineCnt [2];
   logic [1:0] curCnt  [2];

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         curCnt[p] = pktIn[p].frameStart ? 2'h0 : lineCnt[p];
      end
   end

   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         for (int p = 0; p < 2; p++) begin
            lineCnt[p] <= 2'h0;
            dtOut[p]   <= 6'h00;
         end
         dtValid <= 2'h0;
      end else begin
         for (int p = 0; p < 2; p++) begin
            dtValid[p] <= pktIn[p].longPkt;
            if (pktIn[p].longPkt) begin
               if (!rawMode[p]) begin
                  dtOut[p] <= pktIn[p].csiType;                                      // RULE_05
               end else if (curCnt[p] < embedReg[p][EMB_CNT_HI:EMB_CNT_LO]) begin
                  dtOut[p] <= embedReg[p][EMB_CODE_HI:0];                            // RULE_04 RULE_06
               end else begin
                  dtOut[p] <= pktIn[p].rawTwelve ? rawTwelveCode : rawTenCode;     // RULE_03
               end
               if (curCnt[p] != 2'h3) begin
                  lineCnt[p] <= curCnt[p] + 2'h1;
               end else begin
                  lineCnt[p] <= curCnt[p];
               end
            end else if (pktIn[p].frameStart) begin
               lineCnt[p] <= 2'h0;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Assertions.

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);

   property p_crc_flag;
      crcErrIn[0] |=> crcErrFlag[0] == $past(crcEn[0]);
   endproperty
   a_crc_flag: assert property (p_crc_flag) else $error("CRC flag does not follow enable."); // RULE_01

   property p_raw_type;
      pktIn[0].longPkt && rawMode[0] && embedReg[0][EMB_CNT_HI:EMB_CNT_LO] == 2'h0
         |=> dtOut[0] == ($past(pktIn[0].rawTwelve) ? $past(rawTwelveCode) : $past(rawTenCode));
   endproperty
   a_raw_type: assert property (p_raw_type) else $error("Raw type not used."); // RULE_03

   property p_embed_first;
      pktIn[0].longPkt && pktIn[0].frameStart && rawMode[0] && embedReg[0][EMB_CNT_HI:EMB_CNT_LO] != 2'h0
         |=> dtOut[0] == $past(embedReg[0][EMB_CODE_HI:0]);
   endproperty
   a_embed_first: assert property (p_embed_first) else $error("First line not embedded."); // RULE_04

   property p_csi_pass;
      pktIn[1].longPkt && !rawMode[1] |=> dtValid[1] && dtOut[1] == $past(pktIn[1].csiType);
   endproperty
   a_csi_pass: assert property (p_csi_pass) else $error("CSI type altered."); // RULE_05

   property p_read_bank;
      req.read && req.source == SRC_LOCAL && req.addr == OFS_RAW_EMBED
         |=> rdValid && rdata == $past(embedReg[readSel[0]]);
   endproperty
   a_read_bank: assert property (p_read_bank) else $error("Wrong bank read."); // RULE_08

   property p_masked_write;
      wrCap && wrEn[srcIdx] == 2'h1 |=> crcEn[1] == $past(crcEn[1]);
   endproperty
   a_masked_write: assert property (p_masked_write) else $error("Disabled bank written."); // RULE_09

   property p_source_apart;
      wrSel && req.source == SRC_LINK0 |=> readSel[0] == $past(readSel[0]) && wrEn[2] == $past(wrEn[2]);
   endproperty
   a_source_apart: assert property (p_source_apart) else $error("Select state shared."); // RULE_10

   property p_phys_local;
      req.read && req.source == SRC_LOCAL && req.addr == OFS_PORT_SEL |=> !rdata[SEL_PHYS_BIT];
   endproperty
   a_phys_local: assert property (p_phys_local) else $error("Local physical port not zero."); // RULE_11

   property p_phys_link;
      req.read && req.source == SRC_LINK1 && req.addr == OFS_PORT_SEL |=> rdata[SEL_PHYS_BIT];
   endproperty
   a_phys_link: assert property (p_phys_link) else $error("Link physical port wrong."); // RULE_12

   property p_reserved;
      req.read && req.addr >= OFS_RSVD_LO && req.addr <= OFS_RSVD_HI |=> rdValid && rdata == 8'h00;
   endproperty
   a_reserved: assert property (p_reserved) else $error("Reserved offset not zero."); // RULE_15

   c_broadcast: cover property (wrCap && wrEn[srcIdx] == 2'h3);
   c_embed_three: cover property (pktIn[0].longPkt && rawMode[0] && curCnt[0] == 2'h2
                                  && embedReg[0][EMB_CNT_HI:EMB_CNT_LO] == 2'h3);
   c_link_read: cover property (req.read && req.source == SRC_LINK1 && req.addr == OFS_LINK_CAP);

endmodule

// ---- rx_page_bank_model.sv ----
`timescale 1ns/1ps
module rx_page_bank_model
   import rx_page_pkg::*;
(
   // Clock and steering from the block.
   input  wire logic       clk_sys,
   input  wire reg_req_t   req,
   input  wire logic [1:0] pageWrite,
   // Read data per port.
   output logic [7:0]      pagedRdata [2]
);
   logic [7:0] mem [2][256];

   always @(posedge clk_sys) begin
      for (int p = 0; p < 2; p++) begin
         if (pageWrite[p]) begin
            mem[p][req.addr] <= req.wdata;
         end
      end
   end

   always_comb begin
      for (int p = 0; p < 2; p++) begin
         pagedRdata[p] = mem[p][req.addr];
      end
   end
endmodule

// ---- rx_port_register_paging_bench.sv ----
`timescale 1ns/1ps
module rx_port_register_paging_bench;
   import rx_page_pkg::*;
   logic       clk_sys = 1'b0;
   logic       rst = 1'b1;
   reg_req_t   req = '0;
   logic [7:0] rdata;
   logic       rdValid;
   logic [1:0] pageWrite;
   logic       pageReadPort;
   logic [7:0] pagedRdata [2];
   logic [1:0] crcErrIn = 2'h0;
   logic [1:0] crcErrFlag;
   logic [1:0] rawMode = 2'h0;
   pkt_t       pktIn [2];
   logic [5:0] rawTenCode = 6'h2B;
   logic [5:0] rawTwelveCode = 6'h2C;
   logic [5:0] dtOut [2];
   logic [1:0] dtValid;
   int         mismatches = 0;
   int         check_count = 0;
   int         seed = 32'hA9D6;
   logic [7:0] rv;
   logic [7:0] d;
   logic [5:0] c;
   logic [5:0] s;
   logic       tw;

   always #4 clk_sys = ~clk_sys;

   rx_port_register_paging dut_u (.clk_sys(clk_sys), .rst(rst), .req(req), .rdata(rdata), .rdValid(rdValid),
      .pageWrite(pageWrite), .pageReadPort(pageReadPort), .pagedRdata(pagedRdata), .crcErrIn(crcErrIn),
      .crcErrFlag(crcErrFlag), .rawMode(rawMode), .pktIn(pktIn), .rawTenCode(rawTenCode),
      .rawTwelveCode(rawTwelveCode), .dtOut(dtOut), .dtValid(dtValid));

   rx_page_bank_model bank_u (.clk_sys(clk_sys), .req(req), .pageWrite(pageWrite), .pagedRdata(pagedRdata));

   ////////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         mismatches++;
         $display("ERROR t=%0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic acc(input logic w, input logic [1:0] src, input logic [7:0] a, input logic [7:0] wd);
      @(posedge clk_sys);
      #1 req = '{w, !w, src, a, wd};
      @(posedge clk_sys);
      #1 req = '0;
      rv = rdata;
      if (!w) begin
         chk({7'h0, rdValid}, 8'h01);
      end
   endtask

   task automatic rdc(input logic [1:0] src, input logic [7:0] a, input logic [7:0] e);
      acc(1'b0, src, a, 8'h00);
      chk(rv, e);
   endtask

   function automatic logic [5:0] expDt(input int n, input int i, input logic raw, input logic t,
                                        input logic [5:0] code, input logic [5:0] csi);
      if (!raw) return csi;
      if (i < n) return code;
      return t ? rawTwelveCode : rawTenCode;
   endfunction

   task automatic pk(input logic fs, input logic [5:0] csi, input logic [5:0] e0, input logic [5:0] e1);
      @(posedge clk_sys);
      #1;
      for (int p = 0; p < 2; p++) begin
         pktIn[p] = '{fs, 1'b1, tw, csi};
      end
      @(posedge clk_sys);
      #1;
      pktIn[0] = '0;
      pktIn[1] = '0;
      chk({6'h0, dtValid}, 8'h03);
      chk({2'h0, dtOut[0]}, {2'h0, e0});
      chk({2'h0, dtOut[1]}, {2'h0, e1});
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #200000;
      mismatches++;
      test_done();
   end

   initial begin
      pktIn[0] = '0;
      pktIn[1] = '0;
      repeat (20) @(posedge clk_sys);
      #1 rst = 1'b0;
      #1 chk({7'h0, pageReadPort}, 8'h00);
      rdc(SRC_LOCAL, 8'h4C, 8'h00);
      rdc(SRC_LINK0, 8'h4C, 8'h01);
      rdc(SRC_LINK1, 8'h4C, 8'h52);
      rdc(SRC_LOCAL, 8'h4B, RAW_EMBED_RESET);
      rdc(SRC_LOCAL, 8'h4A, 8'h00);
      for (logic [7:0] a = 8'h44; a <= 8'h49; a++) begin
         d = $random(seed);
         acc(1'b1, SRC_LOCAL, a, d);
         rdc(SRC_LOCAL, a, 8'h00);
      end
      acc(1'b1, 2'h3, 8'h4C, 8'h13);
      rdc(SRC_LOCAL, 8'h4C, 8'h00);
      rdc(2'h3, 8'h4B, 8'h00);
      $display("reset and reserved test done");
      acc(1'b1, SRC_LOCAL, 8'h4C, 8'h03);
      acc(1'b1, SRC_LOCAL, 8'h4A, 8'hFF);
      rdc(SRC_LINK0, 8'h4C, 8'h01);
      rdc(SRC_LOCAL, 8'h4A, 8'h10);
      acc(1'b1, SRC_LOCAL, 8'h4C, 8'hFD);
      #1 chk({7'h0, pageReadPort}, 8'h01);
      rdc(SRC_LOCAL, 8'h4C, 8'h11);
      acc(1'b1, SRC_LOCAL, 8'h4A, 8'h00);
      rdc(SRC_LOCAL, 8'h4A, 8'h10);
      d = $random(seed);
      acc(1'b1, SRC_LINK1, 8'hD5, d);
      rdc(SRC_LOCAL, 8'hD5, d);
      acc(1'b1, SRC_LOCAL, 8'h4C, 8'h01);
      rdc(SRC_LOCAL, 8'h4A, 8'h00);
      acc(1'b1, SRC_LOCAL, 8'hD5, ~d);
      rdc(SRC_LINK1, 8'hD5, d);
      rdc(SRC_LOCAL, 8'hD5, ~d);
      @(posedge clk_sys);
      #1 crcErrIn = 2'h3;
      @(posedge clk_sys);
      #1 crcErrIn = 2'h0;
      chk({6'h0, crcErrFlag}, 8'h02);
      $display("paging and error flag test done");
      for (int n = 0; n < 4; n++) begin
         for (int m = 0; m < 2; m++) begin
            c = $random(seed);
            acc(1'b1, SRC_LOCAL, 8'h4B, {n[1:0], c});
            rawMode = {m[0], m[0]};
            tw = $random(seed);
            for (int i = 0; i < 4; i++) begin
               s = $random(seed);
               pk(i == 0, s, expDt(n, i, m[0], tw, c, s), expDt(0, i, m[0], tw, c, s));
            end
         end
      end
      $display("data type test done");
      test_done();
   end
endmodule
